// ### rtcc_map.svh
`ifndef RTCC_MAP_SVH
`define RTCC_MAP_SVH

// register indices; byte address on the bus is four times the index
`define RTCC_IDX_SNAP0 6'h00
`define RTCC_IDX_SNAP3 6'h03
`define RTCC_IDX_CTRL 6'h04
`define RTCC_IDX_OSCCTL 6'h05
`define RTCC_IDX_ALARM0 6'h08
`define RTCC_IDX_ALARM3 6'h0B

// clock_control field positions
`define RTCC_BIT_OSC_EN 7
`define RTCC_BIT_MCD_EN 6
`define RTCC_BIT_FAIL 5
`define RTCC_BIT_RUN 4
`define RTCC_BIT_ALARM_EN 3
`define RTCC_BIT_ALARM_AR 2
`define RTCC_BIT_LOAD 1
`define RTCC_BIT_SNAP 0

// oscillator_control field positions
`define RTCC_BIT_AGC 7
`define RTCC_BIT_CRYSTAL_MODE_SELECT 6
`define RTCC_BIT_BIAS2 5

// reset values
`define RTCC_CTRL_RESET 8'h00
`define RTCC_OSCCTL_RESET 3'h0
`define RTCC_BYTE_RESET 8'h00

// bus responses
`define RTCC_RESP_OKAY 2'h0
`define RTCC_RESP_SLVERR 2'h2

// missing clock timeout: time in ns, clock period in ns, cycles rounded down
`define RTCC_MCD_TIME_NS 100000
`define RTCC_CLK_PERIOD_NS 100
`define RTCC_MCD_CYCLES (`RTCC_MCD_TIME_NS / `RTCC_CLK_PERIOD_NS)

`endif

// ### rtcc_pkg.sv
package rtcc_pkg;

	// clock_control as seen by software, msb first
	typedef struct packed {
		logic osc_enable;
		logic missing_clock_detect_enable;
		logic osc_fail_flag;
		logic timer_run;
		logic alarm_enable;
		logic alarm_flag_autoreset;
		logic timer_load_cmd;
		logic timer_snapshot_cmd;
	} rtcc_ctrl_type;

	// writable part of oscillator_control
	typedef struct packed {
		logic gain_control_enable;
		logic crystal_mode_select;
		logic bias_double_enable;
	} rtcc_oscctl_type;

endpackage

// ### rtcc_det_if.sv
`timescale 1ns/1ps
interface rtcc_det_if;
	logic enable;
	logic osc_level;
	logic timeout;

	// detector side
	modport det (input enable, input osc_level, output timeout);
	// controller side
	modport ctl (output enable, output osc_level, input timeout);
endinterface

// ### rtcc_sync.sv
`timescale 1ns/1ps
module rtcc_sync #(
	parameter int unsigned WIDTH = 1
) (
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// asynchronous in, synchronous out
	input wire logic [WIDTH-1:0] d,
	output logic [WIDTH-1:0] q
);

	logic [WIDTH-1:0] meta_q;

	// two flops; the first feeds only the second
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			meta_q <= '0;
			q <= '0;
		end
		else
		begin
			meta_q <= d;
			q <= meta_q;
		end
	end

endmodule // rtcc_sync

// ### rtcc_mcd.sv
`timescale 1ns/1ps
`include "rtcc_map.svh"
module rtcc_mcd #(
	parameter int unsigned TIMEOUT_CYCLES = `RTCC_MCD_CYCLES
) (
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// detector link
	rtcc_det_if.det det
);

	localparam int unsigned CW = $clog2(TIMEOUT_CYCLES + 1);

	logic [CW-1:0] cnt_q;
	logic last_q;
	logic fired_q;
	logic pulse_q;

	// one-shot: fires once per stuck period, rearms on the next level change
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			cnt_q <= '0;
			last_q <= 1'b0;
			fired_q <= 1'b0;
			pulse_q <= 1'b0;
		end
		else
		begin
			last_q <= det.osc_level;
			pulse_q <= 1'b0;
			if (!det.enable || det.osc_level != last_q)
			begin
				cnt_q <= '0;
				fired_q <= 1'b0;
			end
			else if (cnt_q == CW'(TIMEOUT_CYCLES))
			begin
				pulse_q <= !fired_q; // RQ17
				fired_q <= 1'b1;
			end
			else
			begin
				cnt_q <= cnt_q + CW'(1);
			end
		end
	end

	assign det.timeout = pulse_q;

endmodule // rtcc_mcd

// ### rtcc_top.sv
// Summary of operation
// RQ1 - control bit 7 enables the oscillator
// RQ2 - control bit 6 enables missing-clock detection
// RQ3 - detector timeout sets fail flag, software clears
// RQ4 - run bit counts timer, else holds value
// RQ5 - alarm enable gates alarm, write clears flag
// RQ6 - bit 2 reads the alarm event flag
// RQ7 - bit 2 write sets auto-reset, not flag
// RQ8 - alarm flag lasts at most one oscillator cycle; code keeps it set while the timer still matches
// RQ9 - load command self-clears when timer loaded
// RQ10 - snapshot command self-clears when timer copied
// RQ11 - oscillator bit 7 enables gain control
// RQ12 - oscillator bit 6 selects crystal mode
// RQ13 - oscillator bit 5 enables bias doubling
// RQ14 - oscillator bit 4 reports crystal valid
// RQ15 - oscillator bits 3:0 read zero, ignore writes
// RQ16 - control at index 4, oscillator at 5
// RQ17 - stuck oscillator over 100 us is timeout
// RQ18 - load copies bytes in, snapshot copies out
// RQ19 - alarm when timer equals compare value
// RQ20 - auto-reset zeroes timer one cycle after alarm
// RQ21 - oscillator and status cross domains safely
`timescale 1ns/1ps
`include "rtcc_map.svh"
module rtcc_top
	import rtcc_pkg::*;
#(
	parameter int unsigned MCD_TIMEOUT_CYCLES = `RTCC_MCD_CYCLES,
	parameter int unsigned TIMER_WIDTH = 32
) (
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// axi4-lite write address
	input wire logic [7:0] awaddr,
	input wire logic [2:0] awprot,
	input wire logic awvalid,
	output logic awready,
	// axi4-lite write data
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	output logic wready,
	// axi4-lite write response
	output logic [1:0] bresp,
	output logic bvalid,
	input wire logic bready,
	// axi4-lite read address
	input wire logic [7:0] araddr,
	input wire logic [2:0] arprot,
	input wire logic arvalid,
	output logic arready,
	// axi4-lite read data
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	output logic rvalid,
	input wire logic rready,
	// oscillator pins
	input wire logic osc_clk_in,
	input wire logic crystal_ok_in,
	output logic osc_enable,
	output logic missing_clock_detect_enable,
	output logic gain_control_enable,
	output logic crystal_mode_select,
	output logic bias_double_enable
);

	rtcc_ctrl_type ctrl_q;
	rtcc_oscctl_type oscctl_q;
	logic [7:0] snap_q [4];
	logic [7:0] alarm_q [4];
	logic [TIMER_WIDTH-1:0] timer_q;
	logic [TIMER_WIDTH-1:0] snap_word;
	logic [TIMER_WIDTH-1:0] alarm_word;
	logic autoreset_q;
	logic osc_prev_q;
	logic osc_s;
	logic crystal_valid;
	logic osc_rise;
	logic alarm_hit;
	logic wr_go;
	logic wr_ok;
	logic wr_byte;
	logic ctrl_wr;
	logic [5:0] wr_idx;
	logic [5:0] rd_idx;
	logic rd_ok;
	logic [7:0] rd_byte;
	logic bvalid_q;
	logic rvalid_q;
	logic [1:0] bresp_q;
	logic [1:0] rresp_q;
	logic [31:0] rdata_q;

	rtcc_det_if det_if ();

	// index is mapped when it names one of the ten byte registers
	function automatic logic idx_mapped(input logic [5:0] idx);
		return (idx <= `RTCC_IDX_OSCCTL) || (idx >= `RTCC_IDX_ALARM0 && idx <= `RTCC_IDX_ALARM3);
	endfunction

	// oscillator and crystal detector come from pins
	rtcc_sync #(
		.WIDTH(2)
	) u_pin_sync (
		.aclk(aclk),
		.aresetn(aresetn),
		.d({osc_clk_in, crystal_ok_in}),
		.q({osc_s, crystal_valid}) // RQ21
	);

	// missing clock detector; only watches a running, enabled oscillator
	assign det_if.enable = ctrl_q.missing_clock_detect_enable && ctrl_q.osc_enable; // RQ2
	assign det_if.osc_level = osc_s;

	rtcc_mcd #(
		.TIMEOUT_CYCLES(MCD_TIMEOUT_CYCLES)
	) u_mcd (
		.aclk(aclk),
		.aresetn(aresetn),
		.det(det_if.det)
	);

	// oscillator edge: every slow-domain action happens on this one pulse
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			osc_prev_q <= 1'b0;
		end
		else
		begin
			osc_prev_q <= osc_s;
		end
	end

	assign osc_rise = osc_s && !osc_prev_q && ctrl_q.osc_enable; // RQ21

	// pin outputs straight from the control registers
	assign osc_enable = ctrl_q.osc_enable; // RQ1
	assign missing_clock_detect_enable = ctrl_q.missing_clock_detect_enable;
	assign gain_control_enable = oscctl_q.gain_control_enable; // RQ11
	assign crystal_mode_select = oscctl_q.crystal_mode_select; // RQ12
	assign bias_double_enable = oscctl_q.bias_double_enable; // RQ13

	// write decode: address and data are taken together in one cycle
	assign wr_go = awvalid && wvalid && !bvalid_q;
	assign awready = wr_go;
	assign wready = wr_go;
	assign wr_idx = awaddr[7:2];
	assign wr_ok = awaddr[1:0] == 2'h0 && idx_mapped(wr_idx);
	assign wr_byte = wr_go && wr_ok && wstrb[0];
	assign ctrl_wr = wr_byte && wr_idx == `RTCC_IDX_CTRL; // RQ16

	// words seen by the slow logic
	assign snap_word = {snap_q[3], snap_q[2], snap_q[1], snap_q[0]};
	assign alarm_word = {alarm_q[3], alarm_q[2], alarm_q[1], alarm_q[0]};
	assign alarm_hit = ctrl_q.alarm_enable && timer_q == alarm_word; // RQ19

	// plain control bits
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			ctrl_q.osc_enable <= 1'(`RTCC_CTRL_RESET >> `RTCC_BIT_OSC_EN);
			ctrl_q.missing_clock_detect_enable <= 1'b0;
			ctrl_q.timer_run <= 1'b0;
			ctrl_q.alarm_enable <= 1'b0;
			autoreset_q <= 1'b0;
		end
		else if (ctrl_wr)
		begin
			ctrl_q.osc_enable <= wdata[`RTCC_BIT_OSC_EN]; // RQ1
			ctrl_q.missing_clock_detect_enable <= wdata[`RTCC_BIT_MCD_EN]; // RQ2
			ctrl_q.timer_run <= wdata[`RTCC_BIT_RUN]; // RQ4
			ctrl_q.alarm_enable <= wdata[`RTCC_BIT_ALARM_EN]; // RQ5
			autoreset_q <= wdata[`RTCC_BIT_ALARM_AR]; // RQ7
		end
	end

	// fail flag: writing 0 clears, a timeout in the same cycle wins
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			ctrl_q.osc_fail_flag <= 1'b0;
		end
		else if (det_if.timeout)
		begin
			ctrl_q.osc_fail_flag <= 1'b1; // RQ3
		end
		else if (ctrl_wr && !wdata[`RTCC_BIT_FAIL])
		begin
			ctrl_q.osc_fail_flag <= 1'b0; // RQ3
		end
	end

	// alarm flag: refreshed every oscillator cycle, so it only outlives one while the timer still matches
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			ctrl_q.alarm_flag_autoreset <= 1'b0;
		end
		else if (osc_rise)
		begin
			ctrl_q.alarm_flag_autoreset <= alarm_hit; // RQ8
		end
		else if (ctrl_wr)
		begin
			ctrl_q.alarm_flag_autoreset <= 1'b0; // RQ5
		end
	end

	// command bits: set by software, cleared on the oscillator edge that does the work
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			ctrl_q.timer_load_cmd <= 1'b0;
			ctrl_q.timer_snapshot_cmd <= 1'b0;
		end
		else
		begin
			if (ctrl_wr && wdata[`RTCC_BIT_LOAD])
			begin
				ctrl_q.timer_load_cmd <= 1'b1; // RQ9
			end
			else if (osc_rise)
			begin
				ctrl_q.timer_load_cmd <= 1'b0; // RQ9
			end
			if (ctrl_wr && wdata[`RTCC_BIT_SNAP])
			begin
				ctrl_q.timer_snapshot_cmd <= 1'b1; // RQ10
			end
			else if (osc_rise)
			begin
				ctrl_q.timer_snapshot_cmd <= 1'b0; // RQ10
			end
		end
	end

	// oscillator control; status and low nibble are not stored at all
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			oscctl_q <= `RTCC_OSCCTL_RESET;
		end
		else if (wr_byte && wr_idx == `RTCC_IDX_OSCCTL)
		begin
			oscctl_q <= wdata[`RTCC_BIT_AGC:`RTCC_BIT_BIAS2]; // RQ15
		end
	end

	// timer: load beats auto-reset beats counting
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			timer_q <= '0;
		end
		else if (osc_rise)
		begin
			if (ctrl_q.timer_load_cmd)
			begin
				timer_q <= snap_word; // RQ18
			end
			else if (autoreset_q && ctrl_q.alarm_flag_autoreset)
			begin
				timer_q <= '0; // RQ20
			end
			else if (ctrl_q.timer_run)
			begin
				timer_q <= timer_q + TIMER_WIDTH'(1); // RQ4
			end
		end
	end

	// snapshot bytes: a finishing capture overrides a software write
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			for (int i = 0; i < 4; i++)
			begin
				snap_q[i] <= `RTCC_BYTE_RESET;
			end
		end
		else if (osc_rise && ctrl_q.timer_snapshot_cmd)
		begin
			for (int i = 0; i < 4; i++)
			begin
				snap_q[i] <= timer_q[i*8 +: 8]; // RQ18
			end
		end
		else if (wr_byte && wr_idx <= `RTCC_IDX_SNAP3)
		begin
			snap_q[wr_idx[1:0]] <= wdata[7:0];
		end
	end

	// alarm compare bytes
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			for (int i = 0; i < 4; i++)
			begin
				alarm_q[i] <= `RTCC_BYTE_RESET;
			end
		end
		else if (wr_byte && wr_idx >= `RTCC_IDX_ALARM0 && wr_idx <= `RTCC_IDX_ALARM3)
		begin
			alarm_q[wr_idx[1:0]] <= wdata[7:0];
		end
	end

	// write response; unmapped or misaligned addresses get slverr
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			bvalid_q <= 1'b0;
			bresp_q <= `RTCC_RESP_OKAY;
		end
		else if (wr_go)
		begin
			bvalid_q <= 1'b1;
			bresp_q <= wr_ok ? `RTCC_RESP_OKAY : `RTCC_RESP_SLVERR;
		end
		else if (bready)
		begin
			bvalid_q <= 1'b0;
		end
	end

	// read mux
	assign rd_idx = araddr[7:2];
	assign rd_ok = araddr[1:0] == 2'h0 && idx_mapped(rd_idx);

	always_comb
	begin
		rd_byte = 8'h00;
		if (rd_idx <= `RTCC_IDX_SNAP3)
		begin
			rd_byte = snap_q[rd_idx[1:0]];
		end
		else if (rd_idx == `RTCC_IDX_CTRL)
		begin
			rd_byte = ctrl_q; // RQ6
		end
		else if (rd_idx == `RTCC_IDX_OSCCTL)
		begin
			rd_byte = {oscctl_q, crystal_valid, 4'h0}; // RQ14 RQ15
		end
		else if (rd_idx >= `RTCC_IDX_ALARM0 && rd_idx <= `RTCC_IDX_ALARM3)
		begin
			rd_byte = alarm_q[rd_idx[1:0]];
		end
	end

	// read channel; one read outstanding, answer one cycle after the address
	assign arready = !rvalid_q;

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			rvalid_q <= 1'b0;
			rresp_q <= `RTCC_RESP_OKAY;
			rdata_q <= 32'h00000000;
		end
		else if (arvalid && !rvalid_q)
		begin
			rvalid_q <= 1'b1;
			rresp_q <= rd_ok ? `RTCC_RESP_OKAY : `RTCC_RESP_SLVERR;
			rdata_q <= rd_ok ? {24'h000000, rd_byte} : 32'h00000000;
		end
		else if (rready)
		begin
			rvalid_q <= 1'b0;
		end
	end

	assign bvalid = bvalid_q;
	assign bresp = bresp_q;
	assign rvalid = rvalid_q;
	assign rresp = rresp_q;
	assign rdata = rdata_q;

endmodule // rtcc_top

// ### rtcc_top_chk.sv
`timescale 1ns/1ps
module rtcc_chk #(
	parameter int unsigned MCD_TIMEOUT_CYCLES = 1000
) (
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// write side
	input wire logic [7:0] awaddr,
	input wire logic awvalid,
	input wire logic awready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	input wire logic wready,
	input wire logic [1:0] bresp,
	input wire logic bvalid,
	input wire logic bready,
	// read side
	input wire logic [7:0] araddr,
	input wire logic arvalid,
	input wire logic arready,
	input wire logic [31:0] rdata,
	input wire logic [1:0] rresp,
	input wire logic rvalid,
	input wire logic rready,
	// oscillator controls
	input wire logic osc_enable,
	input wire logic missing_clock_detect_enable,
	input wire logic gain_control_enable,
	input wire logic crystal_mode_select,
	input wire logic bias_double_enable
);
	logic [7:0] ra_q;
	logic wr_go;
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	// read address kept so the answer can be judged by register
	always_ff @(posedge aclk)
	begin
		if (arvalid && arready)
			ra_q <= araddr;
	end
	assign wr_go = awvalid && awready && wstrb[0];
	// both channels are accepted together, so the two readies must agree
	property p_aw_both; awready == (awvalid && wvalid && !bvalid) && wready == awready; endproperty
	a_aw_both: assert property (p_aw_both) else $error("write taken without both channels");
	property p_b_next; awvalid && awready |=> bvalid; endproperty
	a_b_next: assert property (p_b_next) else $error("no write response");
	property p_b_hold; bvalid && !bready |=> bvalid && $stable(bresp); endproperty
	a_b_hold: assert property (p_b_hold) else $error("write response dropped");
	property p_r_hold; rvalid && !rready |=> rvalid && $stable(rdata); endproperty
	a_r_hold: assert property (p_r_hold) else $error("read data dropped");
	property p_bad_rd; arvalid && arready && araddr == 8'h18 |=> rvalid && rresp == 2'h2 && rdata == 32'h0; endproperty
	a_bad_rd: assert property (p_bad_rd) else $error("unmapped read not refused");
	property p_osc_low; rvalid && ra_q == 8'h14 |-> rdata[3:0] == 4'h0 && rdata[31:8] == 24'h0; endproperty
	a_osc_low: assert property (p_osc_low) else $error("unused bits not zero");
	property p_ctl_wr; wr_go && awaddr == 8'h10 |=> {osc_enable, missing_clock_detect_enable} == $past(wdata[7:6]); endproperty
	a_ctl_wr: assert property (p_ctl_wr) else $error("control outputs wrong");
	property p_osc_wr; wr_go && awaddr == 8'h14
		|=> {gain_control_enable, crystal_mode_select, bias_double_enable} == $past(wdata[7:5]); endproperty
	a_osc_wr: assert property (p_osc_wr) else $error("oscillator outputs wrong");
	property p_en_hold; !(awvalid && awready) |=> $stable(osc_enable); endproperty
	a_en_hold: assert property (p_en_hold) else $error("enable moved without write");
	// main traffic seen
	c_ctl: cover property (wr_go && awaddr == 8'h10);
	c_osc: cover property (rvalid && ra_q == 8'h14);
	c_bad: cover property (bvalid && bresp == 2'h2);
endmodule // rtcc_chk
bind rtcc_top rtcc_chk #(.MCD_TIMEOUT_CYCLES(MCD_TIMEOUT_CYCLES)) u_chk (.*);

// ### rtc_control_and_oscillator_regs_tb.sv
`timescale 1ns/1ps
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin errors++; \
	$display("BAD t=%0t got=%h exp=%h", $time, a, b); end end
module rtc_control_and_oscillator_regs_tb;
	logic aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
	logic awready, wready, bvalid, arready, rvalid, osc_go = 0, osc_clk_in = 0, crystal_ok_in = 0;
	logic osc_enable, missing_clock_detect_enable, gain_control_enable, crystal_mode_select, bias_double_enable;
	logic [7:0] awaddr = 0, araddr = 0;
	logic [31:0] wdata = 0, rdata, v, t1, t2, r;
	logic [1:0] bresp, rresp, e, oc = 0;
	logic [3:0] wstrb = 4'hF;
	logic [7:0] x;
	int errors = 0, n_checks = 0, k, seen;
	// timeout kept small so the stuck-clock case stays short
	rtcc_top #(.MCD_TIMEOUT_CYCLES(20)) dut (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awprot(3'h0),
		.awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
		.bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arprot(3'h0), .arvalid(arvalid),
		.arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
		.osc_clk_in(osc_clk_in), .crystal_ok_in(crystal_ok_in), .osc_enable(osc_enable),
		.missing_clock_detect_enable(missing_clock_detect_enable), .gain_control_enable(gain_control_enable),
		.crystal_mode_select(crystal_mode_select), .bias_double_enable(bias_double_enable));
	initial
	begin
		forever #50 aclk = !aclk;
	end
	// oscillator pin toggles every four cycles, well below a quarter of aclk
	always @(posedge aclk)
	begin
		oc <= oc + 2'h1;
		if (osc_go && oc == 2'h3)
			osc_clk_in <= !osc_clk_in;
	end
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
		@(posedge aclk);
		awaddr <= a; wdata <= d; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
		do @(posedge aclk); while (awready !== 1'b1);
		awvalid <= 1'b0; wvalid <= 1'b0;
		do @(posedge aclk); while (bvalid !== 1'b1);
		bready <= 1'b0;
		`CHK(bresp, er)
	endtask
	task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] er);
		@(posedge aclk);
		araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
		do @(posedge aclk); while (arready !== 1'b1);
		arvalid <= 1'b0;
		do @(posedge aclk); while (rvalid !== 1'b1);
		d = rdata; er = rresp; rready <= 1'b0;
	endtask
	// issue a self-clearing command and poll it down
	task automatic cmd(input logic [7:0] c, input int b);
		wr(8'h10, {24'h0, c}, 2'h0);
		k = 0;
		do begin rd(8'h10, r, e); k++; end while (r[b] === 1'b1 && k < 50);
		`CHK(r[b], 1'b0)
	endtask
	task automatic snap(input logic [7:0] c, output logic [31:0] t);
		cmd(c | 8'h01, 0);
		for (int i = 0; i < 4; i++) begin rd(8'(4 * i), r, e); t[8 * i +: 8] = r[7:0]; end
	endtask
	task automatic test_done();
		$display("checks %0d errors %0d", n_checks, errors);
		if (errors == 0 && n_checks > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask
	initial
	begin
		#(20000 * 100);
		errors++;
		test_done();
	end
	initial
	begin
		void'($urandom(70));
		repeat (12) @(posedge aclk);
		aresetn <= 1'b1;
		rd(8'h10, r, e); `CHK(r, 32'h0)
		rd(8'h14, r, e); `CHK(r, 32'h0)
		$display("reset values done");
		for (int i = 0; i < 8; i++)
		begin
			x = 8'($urandom);
			crystal_ok_in <= 1'($urandom);
			wr(8'h14, {24'hFFFFFF, x}, 2'h0);
			`CHK({gain_control_enable, crystal_mode_select, bias_double_enable}, x[7:5])
			repeat (4) @(posedge aclk);
			rd(8'h14, r, e); `CHK(r, {24'h0, x[7:5], crystal_ok_in, 4'h0})
		end
		$display("oscillator control done");
		wr(8'h11, 32'h0, 2'h2);
		rd(8'h18, r, e); `CHK({e, r}, {2'h2, 32'h0})
		// a write with the low strobe off is answered but must leave the register alone
		wstrb <= 4'h0;
		wr(8'h14, {24'h0, ~x}, 2'h0);
		wstrb <= 4'hF;
		rd(8'h14, r, e); `CHK(r[7:5], x[7:5])
		$display("refusals done");
		wr(8'h10, 32'hC0, 2'h0);
		`CHK({osc_enable, missing_clock_detect_enable}, 2'h3)
		rd(8'h10, r, e); `CHK(r[5], 1'b0)
		repeat (40) @(posedge aclk);
		rd(8'h10, r, e); `CHK(r[7:4], 4'hE)
		wr(8'h10, 32'h80, 2'h0);
		repeat (40) @(posedge aclk);
		rd(8'h10, r, e); `CHK(r[7:4], 4'h8)
		$display("missing clock done");
		osc_go <= 1'b1;
		v = $urandom;
		for (int i = 0; i < 4; i++) wr(8'(4 * i), {24'h0, v[8 * i +: 8]}, 2'h0);
		cmd(8'h82, 1);
		snap(8'h80, t1); `CHK(t1, v)
		wr(8'h10, 32'h90, 2'h0);
		repeat (80) @(posedge aclk);
		snap(8'h80, t1); `CHK(t1 != v, 1'b1)
		repeat (40) @(posedge aclk);
		snap(8'h80, t2); `CHK(t2, t1)
		$display("timer done");
		v = t1 + 32'h2;
		for (int i = 0; i < 4; i++) wr(8'(8'h20 + 4 * i), {24'h0, v[8 * i +: 8]}, 2'h0);
		wr(8'h10, 32'h9C, 2'h0);
		seen = 0; k = 0;
		while (seen == 0 && k < 60) begin rd(8'h10, r, e); seen = (r[2] === 1'b1); k++; end
		`CHK(seen, 1)
		// a control write clears the flag unless it meets an oscillator edge, so let the auto-reset edge pass before the next command
		repeat (16) @(posedge aclk);
		rd(8'h10, r, e); `CHK(r[2], 1'b0)
		snap(8'h8C, t2); `CHK(t2 < 32'h10, 1'b1)
		$display("alarm done");
		test_done();
	end
endmodule // rtc_control_and_oscillator_regs_tb
